// ---- hdl/cgs_consts.vh ----
// Constants for the clock generation and selection block.
// Assumes inclusion by the design file and the testbench; definitions only.
`ifndef CGS_CONSTS_VH
`define CGS_CONSTS_VH
// ****************************************
// Register word indices and byte addresses
// ****************************************
`define CGS_IDX_LOOP_CONTROL 8'h3C
`define CGS_IDX_CLOCK_SOURCE_SELECT 8'h3D
`define CGS_IDX_SLOW_CLOCK_DIVIDER 8'h3E
`define CGS_ADDR_LOOP_CONTROL 10'h0F0
`define CGS_ADDR_CLOCK_SOURCE_SELECT 10'h0F4
`define CGS_ADDR_SLOW_CLOCK_DIVIDER 10'h0F8
`define CGS_ADDR_LOOP_MULTIPLIER 10'h100
`define CGS_ADDR_REFERENCE_DIVIDER 10'h104
`define CGS_ADDR_LOOP_FLAGS 10'h108
`define CGS_ADDR_CLOCK_STATUS 10'h10C
// ****************************************
// Loop control fields
// ****************************************
`define CGS_LC_SETTLE_IE 7
`define CGS_LC_POWER_ON 6
`define CGS_LC_AUTO_BW 5
`define CGS_LC_TRACK_BW 4
`define CGS_LC_STOP_KEEP 2
`define CGS_LC_LIMP_IE 1
`define CGS_LC_LIMP_DIS 0
// ****************************************
// Loop flag fields
// ****************************************
`define CGS_LF_SETTLE_CHG 3
`define CGS_LF_SETTLED 2
`define CGS_LF_LIMP_CHG 1
`define CGS_LF_LIMP_ACT 0
// ****************************************
// Clock source select fields
// ****************************************
`define CGS_CS_LOOP_SEL 7
`define CGS_CS_LOW_SEL 6
`define CGS_CS_MOD_SRC 5
`define CGS_CS_CAN_SRC 1
`define CGS_CS_DBG_SW 0
// ****************************************
// Reset values and timing
// ****************************************
`define CGS_RST_LOOP_CONTROL 8'h60
`define CGS_RST_ZERO 8'h00
`define CGS_SWITCH_CYCLES 4'h4
`define CGS_SLOW_MAX 6'h3F
`endif

// ---- hdl/cgs_clock_gen.v ----
// Clock generation and selection: registers, dividers and clock muxes.
// Assumes an AXI4-Lite master on mclk; crystal and loop oscillator are
// sampled as enable pulses, every derived clock is a one-cycle enable.
//
// Summary of operation
// - Multiplier writes ignored while loop drives bus.
// - Bus is reference times multiplier plus one.
// - Reference divider plus one; writes blocked likewise.
// - Loop clock is two crystal times ratio.
// - Settle change flag on toggle; W1C; limp clears.
// - Settle status read-only, zero in limp-home.
// - Reference loss sets limp, loop clock used.
// - Limp change flag on entry or exit; W1C.
// - Settle irq enable forced zero without supply.
// - Power-on uncleared while loop selected; limp forces.
// - Auto bandwidth picks acquisition or tracking itself.
// - Manual bandwidth: zero high, one low.
// - Stop keep-running holds oscillator during stop.
// - Limp disable chooses monitor reset; write once.
// - Loop select needs loop on; limp forces one.
// - Low-speed select chooses crystal or slow clock.
// - Module clock peripheral or prescaled; limp zero.
// - Slow clock divides crystal by twice value.
// - New slow value applies within one period.
// - E, peripheral halve system; prescaled halves slow.
// - CAN and debug clocks follow their selects.
// - Limp-home derives clocks from loop oscillator.
// - Source change holds select low, stalls processor; only loop select changes do so, not low-speed select.
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/100ps
`include "cgs_consts.vh"

module cgs_clock_gen (
    // Clock and reset
    input wire mclk,
    input wire rst_n,
    // AXI4-Lite slave
    input wire [9:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [9:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Pins and analog status
    input wire crystal_input_clock,
    input wire loop_osc_clock,
    input wire loop_supply_level,
    input wire reference_lost,
    input wire loop_in_tolerance,
    input wire loop_freq_near,
    input wire special_mode,
    input wire stop_request,
    // Derived clock enables
    output reg system_clock,
    output reg e_bus_clock,
    output reg peripheral_clock,
    output reg module_clock,
    output reg low_speed_clock,
    output reg prescaled_low_speed_clock,
    output reg debug_base_clock,
    output reg can_clock,
    output reg debug_clock,
    output reg loop_output_clock,
    // Loop and system control
    output reg [7:0] loop_mult_out,
    output reg [7:0] ref_div_out,
    output reg loop_enable,
    output reg loop_low_bandwidth,
    output reg osc_keep_running,
    output reg clock_select_ok,
    output reg cpu_stall,
    output reg monitor_reset,
    output reg settle_irq,
    output reg limp_irq
);

// ****************************************
// Input synchronisers
// ****************************************
reg [2:0] xtal_s_q, vco_s_q, sup_s_q, lost_s_q, tol_s_q, near_s_q;
reg xtal_lvl_q, vco_lvl_q, sup_q, lost_q, tol_q, near_q;

always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        xtal_s_q <= 3'h0;
        vco_s_q <= 3'h0;
        sup_s_q <= 3'h7;
        lost_s_q <= 3'h0;
        tol_s_q <= 3'h0;
        near_s_q <= 3'h0;
        xtal_lvl_q <= 1'b0;
        vco_lvl_q <= 1'b0;
        sup_q <= 1'b1;
        lost_q <= 1'b0;
        tol_q <= 1'b0;
        near_q <= 1'b0;
    end else begin
        xtal_s_q <= {xtal_s_q[1:0], crystal_input_clock};
        vco_s_q <= {vco_s_q[1:0], loop_osc_clock};
        sup_s_q <= {sup_s_q[1:0], loop_supply_level};
        lost_s_q <= {lost_s_q[1:0], reference_lost};
        tol_s_q <= {tol_s_q[1:0], loop_in_tolerance};
        near_s_q <= {near_s_q[1:0], loop_freq_near};
        if (xtal_s_q[1] == xtal_s_q[2])
            xtal_lvl_q <= xtal_s_q[2];
        if (vco_s_q[1] == vco_s_q[2])
            vco_lvl_q <= vco_s_q[2];
        if (sup_s_q[1] == sup_s_q[2])
            sup_q <= sup_s_q[2];
        if (lost_s_q[1] == lost_s_q[2])
            lost_q <= lost_s_q[2];
        if (tol_s_q[1] == tol_s_q[2])
            tol_q <= tol_s_q[2];
        if (near_s_q[1] == near_s_q[2])
            near_q <= near_s_q[2];
    end
end

wire xtal_tick = (xtal_s_q[1] == xtal_s_q[2]) & xtal_s_q[2] & ~xtal_lvl_q;
wire vco_tick = (vco_s_q[1] == vco_s_q[2]) & vco_s_q[2] & ~vco_lvl_q;

// ****************************************
// Registers
// ****************************************
reg [7:0] mult_q, reference_divider_q, ctrl_q, csel_q;
reg [5:0] slow_q;
reg settle_chg_q, limp_chg_q, limp_q, settled_q, limp_disable_wr_q;

wire limp_en = limp_q & ~ctrl_q[`CGS_LC_LIMP_DIS];
wire loop_sel = csel_q[`CGS_CS_LOOP_SEL] | limp_en;
wire settled_now = tol_q & ctrl_q[`CGS_LC_POWER_ON] & ~limp_en;

// AXI write channel capture
reg [9:0] awaddr_q;
reg [31:0] wdata_q;
reg [3:0] wstrb_q;
reg aw_have_q, w_have_q;
wire wr_go = aw_have_q & w_have_q & ~s_axi_bvalid;
wire [7:0] wd = wdata_q[7:0];
wire wl = wstrb_q[0];

always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= 2'h0;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        awaddr_q <= 10'h000;
        wdata_q <= 32'h0000_0000;
        wstrb_q <= 4'h0;
        mult_q <= `CGS_RST_ZERO;
        reference_divider_q <= `CGS_RST_ZERO;
        ctrl_q <= `CGS_RST_LOOP_CONTROL;
        csel_q <= `CGS_RST_ZERO;
        slow_q <= 6'h00;
        settle_chg_q <= 1'b0;
        limp_chg_q <= 1'b0;
        limp_q <= 1'b0;
        settled_q <= 1'b0;
        limp_disable_wr_q <= 1'b0;
    end else begin
        if (s_axi_awvalid & s_axi_awready) begin
            awaddr_q <= s_axi_awaddr;
            aw_have_q <= 1'b1;
            s_axi_awready <= 1'b0;
        end
        if (s_axi_wvalid & s_axi_wready) begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
            w_have_q <= 1'b1;
            s_axi_wready <= 1'b0;
        end
        if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
        end
        // Status tracking
        settled_q <= settled_now;
        limp_q <= lost_q;
        // Hardware sets win over software clears
        if (limp_en)
            settle_chg_q <= 1'b0;
        else if (settled_now != settled_q)
            settle_chg_q <= 1'b1;
        else if (wr_go & wl & awaddr_q == `CGS_ADDR_LOOP_FLAGS
                 & wd[`CGS_LF_SETTLE_CHG])
            settle_chg_q <= 1'b0;
        if (lost_q != limp_q & ~ctrl_q[`CGS_LC_LIMP_DIS])
            limp_chg_q <= 1'b1;
        else if (wr_go & wl & awaddr_q == `CGS_ADDR_LOOP_FLAGS
                 & wd[`CGS_LF_LIMP_CHG])
            limp_chg_q <= 1'b0;
        // Loop supply absent forces control bits
        if (!sup_q) begin
            ctrl_q[`CGS_LC_SETTLE_IE] <= 1'b0;
            ctrl_q[`CGS_LC_LIMP_IE] <= 1'b0;
            ctrl_q[`CGS_LC_POWER_ON] <= 1'b0;
            ctrl_q[`CGS_LC_LIMP_DIS] <= 1'b1;
            csel_q[`CGS_CS_LOOP_SEL] <= 1'b0;
        end
        if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_bresp <= 2'h0;
            case (awaddr_q)
                `CGS_ADDR_LOOP_MULTIPLIER: begin
                    if (wl & ~loop_sel)
                        mult_q <= wd;
                end
                `CGS_ADDR_REFERENCE_DIVIDER: begin
                    if (wl & ~loop_sel)
                        reference_divider_q <= wd;
                end
                `CGS_ADDR_LOOP_CONTROL: begin
                    if (wl & sup_q) begin
                        ctrl_q[7] <= wd[7];
                        ctrl_q[`CGS_LC_POWER_ON] <= wd[6]
                            | csel_q[`CGS_CS_LOOP_SEL];
                        ctrl_q[5:4] <= wd[5:4];
                        ctrl_q[2:1] <= wd[2:1];
                        if (special_mode | ~limp_disable_wr_q) begin
                            ctrl_q[0] <= wd[0];
                            limp_disable_wr_q <= ~special_mode;
                        end
                    end
                end
                `CGS_ADDR_CLOCK_SOURCE_SELECT: begin
                    if (wl) begin
                        csel_q[`CGS_CS_LOOP_SEL] <= wd[7] & sup_q
                            & ctrl_q[`CGS_LC_POWER_ON];
                        csel_q[6:5] <= wd[6:5];
                        csel_q[1:0] <= wd[1:0];
                    end
                end
                `CGS_ADDR_SLOW_CLOCK_DIVIDER: begin
                    if (wl)
                        slow_q <= wd[5:0];
                end
                `CGS_ADDR_LOOP_FLAGS: begin
                end
                default: s_axi_bresp <= 2'h2;
            endcase
        end
    end
end

// ****************************************
// Read channel
// ****************************************
reg [7:0] rd_d;
reg rd_ok;

always @* begin
    rd_d = 8'h00;
    rd_ok = 1'b1;
    case (s_axi_araddr)
        `CGS_ADDR_LOOP_MULTIPLIER: rd_d = mult_q;
        `CGS_ADDR_REFERENCE_DIVIDER: rd_d = reference_divider_q;
        `CGS_ADDR_LOOP_CONTROL: rd_d = {ctrl_q[7:5],
            ctrl_q[`CGS_LC_AUTO_BW] ? near_q : ctrl_q[4], 1'b0,
            ctrl_q[2:0]};
        `CGS_ADDR_CLOCK_SOURCE_SELECT: rd_d = {csel_q[7:5], 3'h0,
            csel_q[1:0]};
        `CGS_ADDR_SLOW_CLOCK_DIVIDER: rd_d = {2'h0, slow_q};
        `CGS_ADDR_LOOP_FLAGS: rd_d = {4'h0, settle_chg_q, settled_q,
            limp_chg_q, limp_en};
        `CGS_ADDR_CLOCK_STATUS: rd_d = {5'h0, cpu_stall, loop_sel,
            loop_enable};
        default: rd_ok = 1'b0;
    endcase
end

always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid & s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_d};
        s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
    end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
    end
end

// ****************************************
// Clock dividers and selection
// ****************************************
reg [6:0] slow_cnt_q;
reg sys_ph_q, low_ph_q, xt_ph_q, sw_busy_q;
reg [3:0] sw_cnt_q;
reg sel_prev_q;

wire slow_tick = (slow_q == 6'h00) ? xtal_tick
    : (xtal_tick & slow_cnt_q >= {slow_q, 1'b0} - 7'h01);
wire sel_low = csel_q[`CGS_CS_LOW_SEL] & ~loop_sel;
wire sys_src = loop_sel ? vco_tick
    : (sel_low ? slow_tick : xtal_tick);
wire sys_tick = sys_src & ~sw_busy_q;
wire half_sys = sys_tick & sys_ph_q;
wire half_low = limp_en ? half_sys : (slow_tick & low_ph_q);
wire mod_sel = csel_q[`CGS_CS_MOD_SRC] & ~limp_en;
wire half_xt = limp_en ? half_sys : (xtal_tick & xt_ph_q);
wire slower = sel_low & (slow_q != 6'h00);
wire dbg_base = slower ? half_sys : half_xt;

always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        slow_cnt_q <= 7'h00;
        sys_ph_q <= 1'b0;
        low_ph_q <= 1'b0;
        xt_ph_q <= 1'b0;
        sw_busy_q <= 1'b0;
        sw_cnt_q <= 4'h0;
        sel_prev_q <= 1'b0;
    end else begin
        // Counter restarts when it passes a freshly written value
        if (xtal_tick)
            slow_cnt_q <= slow_tick ? 7'h00 : slow_cnt_q + 7'h01;
        if (slow_tick)
            low_ph_q <= ~low_ph_q;
        if (xtal_tick)
            xt_ph_q <= ~xt_ph_q;
        if (sys_tick)
            sys_ph_q <= ~sys_ph_q;
        sel_prev_q <= loop_sel;
        if (sel_prev_q != loop_sel) begin
            sw_busy_q <= 1'b1;
            sw_cnt_q <= `CGS_SWITCH_CYCLES;
        end else if (sw_busy_q) begin
            if (sw_cnt_q == 4'h0)
                sw_busy_q <= 1'b0;
            else
                sw_cnt_q <= sw_cnt_q - 4'h1;
        end
    end
end

// ****************************************
// Registered outputs
// ****************************************
always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        system_clock <= 1'b0;
        e_bus_clock <= 1'b0;
        peripheral_clock <= 1'b0;
        module_clock <= 1'b0;
        low_speed_clock <= 1'b0;
        prescaled_low_speed_clock <= 1'b0;
        debug_base_clock <= 1'b0;
        can_clock <= 1'b0;
        debug_clock <= 1'b0;
        loop_output_clock <= 1'b0;
        loop_mult_out <= 8'h00;
        ref_div_out <= 8'h00;
        loop_enable <= 1'b0;
        loop_low_bandwidth <= 1'b0;
        osc_keep_running <= 1'b0;
        clock_select_ok <= 1'b0;
        cpu_stall <= 1'b0;
        monitor_reset <= 1'b0;
        settle_irq <= 1'b0;
        limp_irq <= 1'b0;
    end else begin
        system_clock <= sys_tick;
        e_bus_clock <= half_sys;
        peripheral_clock <= half_sys;
        low_speed_clock <= slow_tick;
        prescaled_low_speed_clock <= half_low;
        module_clock <= mod_sel ? half_low : half_sys;
        debug_base_clock <= dbg_base;
        can_clock <= csel_q[`CGS_CS_CAN_SRC] ? sys_tick
            : xtal_tick;
        debug_clock <= csel_q[`CGS_CS_DBG_SW] ? half_sys
            : dbg_base;
        loop_output_clock <= vco_tick;
        loop_mult_out <= mult_q;
        ref_div_out <= reference_divider_q;
        loop_enable <= ctrl_q[`CGS_LC_POWER_ON] | limp_en;
        loop_low_bandwidth <= ctrl_q[`CGS_LC_AUTO_BW] ? near_q
            : ctrl_q[`CGS_LC_TRACK_BW];
        osc_keep_running <= stop_request
            & ctrl_q[`CGS_LC_STOP_KEEP];
        clock_select_ok <= ~sw_busy_q;
        cpu_stall <= sw_busy_q;
        monitor_reset <= lost_q & ctrl_q[`CGS_LC_LIMP_DIS];
        settle_irq <= settle_chg_q & ctrl_q[`CGS_LC_SETTLE_IE];
        limp_irq <= limp_chg_q & ctrl_q[`CGS_LC_LIMP_IE];
    end
end

endmodule // cgs_clock_gen

// ---- testbench/cgs_chk.sv ----
// Checker: port-level assertions for the clock generation block.
// Assumes binding to cgs_clock_gen, one mclk domain, async rst_n.
`timescale 1ns/100ps
module cgs_chk (
    // Clock and reset
    input wire mclk,
    input wire rst_n,
    // Bus handshakes
    input wire s_axi_awready,
    input wire s_axi_wready,
    input wire s_axi_wvalid,
    input wire s_axi_bvalid,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    // Status inputs
    input wire loop_supply_level,
    input wire reference_lost,
    input wire stop_request,
    // Observed outputs
    input wire e_bus_clock,
    input wire peripheral_clock,
    input wire [7:0] loop_mult_out,
    input wire [7:0] ref_div_out,
    input wire loop_enable,
    input wire osc_keep_running,
    input wire clock_select_ok,
    input wire cpu_stall,
    input wire monitor_reset,
    input wire settle_irq,
    input wire limp_irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // ****************************************
    // Sequences
    // ****************************************
    sequence s_no_supply; !loop_supply_level [*8]; endsequence
    sequence s_switch; cpu_stall ##[1:20] clock_select_ok; endsequence
    sequence s_quiet_write; !s_axi_wvalid [*6]; endsequence
    // ****************************************
    // Assertions
    // ****************************************
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid) else $error("read answer missing");
    a_write_busy: assert property (s_axi_bvalid |->
        !s_axi_awready && !s_axi_wready) else $error("write not held off");
    a_divider_stable: assert property (
        s_quiet_write |-> $stable(loop_mult_out) && $stable(ref_div_out))
        else $error("ratio changed without write");
    a_stall_excl: assert property (
        clock_select_ok |-> !cpu_stall) else $error("stall while ready");
    a_switch_done: assert property (
        $fell(clock_select_ok) |-> s_switch) else $error("switch stuck");
    a_irq_supply: assert property (
        s_no_supply |-> !settle_irq && !limp_irq)
        else $error("irq without supply");
    a_loop_supply: assert property (
        s_no_supply |-> !loop_enable) else $error("loop on without supply");
    a_keep_stop: assert property (
        !stop_request [*8] |-> !osc_keep_running)
        else $error("oscillator held outside stop");
    a_mon_reset: assert property (
        !reference_lost [*8] |-> !monitor_reset)
        else $error("monitor reset without loss");
    a_e_periph: assert property (
        e_bus_clock == peripheral_clock) else $error("e and p clocks differ");
endmodule // cgs_chk

bind cgs_clock_gen cgs_chk i_cgs_chk (.mclk(mclk), .rst_n(rst_n),
    .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .loop_supply_level(loop_supply_level),
    .reference_lost(reference_lost), .stop_request(stop_request),
    .e_bus_clock(e_bus_clock), .peripheral_clock(peripheral_clock),
    .loop_mult_out(loop_mult_out), .ref_div_out(ref_div_out),
    .loop_enable(loop_enable), .osc_keep_running(osc_keep_running),
    .clock_select_ok(clock_select_ok), .cpu_stall(cpu_stall),
    .monitor_reset(monitor_reset), .settle_irq(settle_irq),
    .limp_irq(limp_irq));

// ---- testbench/cgs_clock_gen_tb_top.sv ----
// Testbench: AXI4-Lite register tests and clock ratio counts.
// Assumes cgs_consts.vh on the include path and the bound checker.
`timescale 1ns/100ps
`include "cgs_consts.vh"
module cgs_clock_gen_tb_top;
    logic mclk = 0, rst_n = 0, xtal = 0, osc = 0, supply = 1, ref_lost = 0;
    logic in_tol = 0, near = 0, stop_req = 0, meas = 0, spec = 0;
    logic awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
    logic [9:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, rd_data;
    logic [1:0] rd_resp;
    wire awr, wr_r, bv, arr, rv, sys, e, p, m, sl, px, dbb, cn, dbg;
    wire lp_en, low_bw, keep, sel_ok, stall, mon, s_irq, l_irq, lpo;
    wire [1:0] br, rr;
    wire [31:0] rdt;
    wire [7:0] mult_o, rdiv_o;
    int fail_count = 0, checked = 0, tick = 0;
    int nx, nsys, ne, np, nm, nsl, npx, ncan, ndbg, ndbb, nlp;

    cgs_clock_gen i_cgs_clock_gen (.mclk(mclk), .rst_n(rst_n),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
        .s_axi_wready(wr_r), .s_axi_bresp(br), .s_axi_bvalid(bv),
        .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdt), .s_axi_rresp(rr),
        .s_axi_rvalid(rv), .s_axi_rready(rry), .crystal_input_clock(xtal),
        .loop_osc_clock(osc), .loop_supply_level(supply),
        .reference_lost(ref_lost), .loop_in_tolerance(in_tol),
        .loop_freq_near(near), .special_mode(spec),
        .stop_request(stop_req), .system_clock(sys), .e_bus_clock(e),
        .peripheral_clock(p), .module_clock(m), .low_speed_clock(sl),
        .prescaled_low_speed_clock(px), .debug_base_clock(dbb),
        .can_clock(cn), .debug_clock(dbg), .loop_output_clock(lpo),
        .loop_mult_out(mult_o), .ref_div_out(rdiv_o), .loop_enable(lp_en),
        .loop_low_bandwidth(low_bw), .osc_keep_running(keep),
        .clock_select_ok(sel_ok), .cpu_stall(stall), .monitor_reset(mon),
        .settle_irq(s_irq), .limp_irq(l_irq));

    // ****************************************
    // Clocks and pulse counters
    // ****************************************
    always #12.5 mclk = ~mclk;
    always @(posedge mclk) begin
        tick <= tick + 1;
        if (tick % 2 == 1) xtal <= ~xtal;
        if (tick % 3 == 2) osc <= ~osc;
        if (meas) begin
            nx += (tick % 2 == 1 && !xtal);
            nsys += sys; ne += e; np += p; nm += m; nsl += sl;
            npx += px; ncan += cn; ndbg += dbg; ndbb += dbb; nlp += lpo;
        end
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic end_sim;
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input [31:0] got, input [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic hang(input int n);
        if (n >= 60) begin
            fail_count++;
            end_sim();
        end
    endtask
    task automatic wr(input [9:0] a, input [31:0] d, input [1:0] er = 0);
        int n;
        n = 0;
        @(posedge mclk);
        awa <= a; wd <= d; awv <= 1; wv <= 1; bry <= 1;
        do begin
            @(posedge mclk);
            n++;
            if (awr) awv <= 0;
            if (wr_r) wv <= 0;
        end while (!bv && n < 60);
        hang(n);
        bry <= 0;
        chk(br, er);
    endtask
    task automatic rc(input [9:0] a, input [31:0] exp, input [1:0] er = 0);
        int n;
        n = 0;
        @(posedge mclk);
        ara <= a; arv <= 1; rry <= 1;
        do begin
            @(posedge mclk);
            n++;
            if (arr) arv <= 0;
        end while (!rv && n < 60);
        hang(n);
        rry <= 0;
        rd_data = rdt;
        rd_resp = rr;
        chk(rd_resp, er);
        if (er == 0) chk(rd_data, exp);
    endtask
    function automatic logic near_to(input int a, input int b);
        return (a - b <= 6) && (b - a <= 6);
    endfunction
    task automatic count(input [7:0] sel);
        wr(`CGS_ADDR_CLOCK_SOURCE_SELECT, sel);
        cyc(20);
        nx = 0; nsys = 0; ne = 0; np = 0; nm = 0;
        nsl = 0; npx = 0; ncan = 0; ndbg = 0; ndbb = 0; nlp = 0;
        meas = 1;
        cyc(400);
        meas = 0;
    endtask

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        cyc(3);
        rst_n <= 1;
        rc(`CGS_ADDR_LOOP_CONTROL, `CGS_RST_LOOP_CONTROL);
        rc(`CGS_ADDR_CLOCK_SOURCE_SELECT, 0);
        rc(`CGS_ADDR_LOOP_MULTIPLIER, 0);
        wr(10'h3FC, 32'hFF, 2'b10);
        rc(10'h3FC, 0, 2'b10);
        $display("test reset and map done");
        wr(`CGS_ADDR_SLOW_CLOCK_DIVIDER, 2);
        count(8'h00);
        chk(near_to(nsl * 4, nx), 1);
        chk(near_to(npx * 2, nsl), 1);
        chk(near_to(ne * 2, nsys), 1);
        chk(near_to(nsys, nx), 1);
        chk(near_to(ncan, nx), 1);
        chk(near_to(nm, np), 1);
        chk(near_to(ndbb * 2, nx), 1);
        chk(near_to(nlp * 3, nx * 2), 1);
        count(8'h63);
        chk(near_to(nsys, nsl), 1);
        chk(near_to(nm, npx), 1);
        chk(near_to(ncan, nsys), 1);
        chk(near_to(ndbg, ne), 1);
        chk(near_to(ndbb, ne), 1);
        wr(`CGS_ADDR_SLOW_CLOCK_DIVIDER, 0);
        count(8'h00);
        chk(near_to(nsl, nx), 1);
        $display("test clock ratios done");
        wr(`CGS_ADDR_LOOP_MULTIPLIER, 5);
        wr(`CGS_ADDR_REFERENCE_DIVIDER, 3);
        cyc(2);
        chk(mult_o, 5);
        chk(rdiv_o, 3);
        wr(`CGS_ADDR_CLOCK_SOURCE_SELECT, 8'h80);
        cyc(12);
        chk(sel_ok, 1);
        rc(`CGS_ADDR_CLOCK_STATUS, 3);
        wr(`CGS_ADDR_LOOP_MULTIPLIER, 8'h0A);
        rc(`CGS_ADDR_LOOP_MULTIPLIER, 5);
        wr(`CGS_ADDR_REFERENCE_DIVIDER, 7);
        rc(`CGS_ADDR_REFERENCE_DIVIDER, 3);
        wr(`CGS_ADDR_LOOP_CONTROL, 8'h20);
        rc(`CGS_ADDR_LOOP_CONTROL, 8'h60);
        wr(`CGS_ADDR_CLOCK_SOURCE_SELECT, 0);
        cyc(12);
        wr(`CGS_ADDR_LOOP_CONTROL, 8'h20);
        rc(`CGS_ADDR_LOOP_CONTROL, 8'h20);
        wr(`CGS_ADDR_CLOCK_SOURCE_SELECT, 8'h80);
        rc(`CGS_ADDR_CLOCK_SOURCE_SELECT, 0);
        $display("test loop select guards done");
        wr(`CGS_ADDR_LOOP_CONTROL, 8'h40);
        cyc(2);
        chk(low_bw, 0);
        wr(`CGS_ADDR_LOOP_CONTROL, 8'h50);
        cyc(2);
        chk(low_bw, 1);
        wr(`CGS_ADDR_LOOP_CONTROL, 8'h64);
        stop_req <= 1;
        cyc(8);
        chk(keep, 1);
        stop_req <= 0;
        wr(`CGS_ADDR_LOOP_CONTROL, 8'h60);
        near <= 1;
        cyc(8);
        chk(low_bw, 1);
        near <= 0;
        cyc(8);
        chk(low_bw, 0);
        $display("test bandwidth and stop done");
        in_tol <= 1;
        cyc(8);
        rc(`CGS_ADDR_LOOP_FLAGS, 8'h0C);
        wr(`CGS_ADDR_LOOP_FLAGS, 0);
        rc(`CGS_ADDR_LOOP_FLAGS, 8'h0C);
        wr(`CGS_ADDR_LOOP_CONTROL, 8'hE0);
        cyc(2);
        chk(s_irq, 1);
        wr(`CGS_ADDR_LOOP_FLAGS, 8'h0C);
        rc(`CGS_ADDR_LOOP_FLAGS, 8'h04);
        chk(s_irq, 0);
        $display("test settle flag done");
        wr(`CGS_ADDR_LOOP_CONTROL, 8'h22);
        ref_lost <= 1;
        in_tol <= 0;
        cyc(8);
        rc(`CGS_ADDR_LOOP_FLAGS, 8'h03);
        chk(lp_en, 1);
        chk(l_irq, 1);
        chk(mon, 0);
        rc(`CGS_ADDR_CLOCK_SOURCE_SELECT, 0);
        ref_lost <= 0;
        cyc(8);
        rc(`CGS_ADDR_LOOP_FLAGS, 8'h02);
        wr(`CGS_ADDR_LOOP_FLAGS, 8'h02);
        rc(`CGS_ADDR_LOOP_FLAGS, 0);
        chk(l_irq, 0);
        $display("test limp home done");
        rst_n <= 0;
        cyc(3);
        rst_n <= 1;
        rc(`CGS_ADDR_LOOP_MULTIPLIER, 0);
        wr(`CGS_ADDR_LOOP_CONTROL, 8'h61);
        wr(`CGS_ADDR_LOOP_CONTROL, 8'h60);
        rc(`CGS_ADDR_LOOP_CONTROL, 8'h61);
        ref_lost <= 1;
        cyc(8);
        chk(mon, 1);
        rc(`CGS_ADDR_LOOP_FLAGS, 0);
        ref_lost <= 0;
        spec <= 1;
        cyc(8);
        wr(`CGS_ADDR_LOOP_CONTROL, 8'h60);
        rc(`CGS_ADDR_LOOP_CONTROL, 8'h60);
        spec <= 0;
        wr(`CGS_ADDR_LOOP_CONTROL, 8'hE3);
        supply <= 0;
        cyc(12);
        rc(`CGS_ADDR_LOOP_CONTROL, 8'h21);
        chk(lp_en, 0);
        $display("test limp disable and supply done");
        end_sim();
    end
endmodule // cgs_clock_gen_tb_top
